//--- shared/seq_exit_pkg.sv
package seq_exit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_FREQ_MHZ   = 20;
  localparam int LOAD_TIME_US   = 20;
  localparam int TICK_US        = 10;
  localparam int CONV_TIME_US   = 500;
  localparam int LOAD_CYCLES    = LOAD_TIME_US * CLK_FREQ_MHZ;
  localparam int TICK_CYCLES    = TICK_US * CLK_FREQ_MHZ;
  localparam int CONV_CYCLES    = CONV_TIME_US * CLK_FREQ_MHZ;
  localparam int SEQ_DELAY_MIN_US = 10;
  localparam int SEQ_DELAY_MAX_MS = 400;
  localparam int TOUT_MIN_US      = 100;
  localparam int TOUT_MAX_MS      = 400;
  localparam logic [15:0] TOUT_MIN_TICKS = 16'(TOUT_MIN_US / TICK_US);
  localparam logic [15:0] DELAY_MAX_TICKS = 16'(SEQ_DELAY_MAX_MS * 1000 / TICK_US);

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_STATES = 8;
  localparam int NUM_CHAN   = 8;
  localparam int TBL_STRIDE = 4;
  localparam int TBL_WORDS  = NUM_STATES * TBL_STRIDE;
  localparam int AVG_PASSES = 16;
  localparam int AVG_SHIFT  = 4;
  localparam int FAULT_HALF = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [11:0] FAULT0_OFS  = 12'h008;
  localparam logic [11:0] FAULT1_OFS  = 12'h00C;
  localparam logic [11:0] SCAN_OFS    = 12'h010;
  localparam logic [11:0] WARN_OFS    = 12'h014;
  localparam logic [11:0] LIMIT_BASE  = 12'h020;
  localparam logic [11:0] RESULT_BASE = 12'h040;
  localparam logic [11:0] TBL_BASE    = 12'h100;
  localparam logic [11:0] TBL_END     = 12'h180;

  // field positions
  localparam int CTRL_JUMP_BIT   = 0;
  localparam int SCAN_EN_BIT     = 8;
  localparam int SCAN_CONT_BIT   = 9;
  localparam int SCAN_AVG_BIT    = 10;
  localparam int LIMIT_UPPER_BIT = 12;

  // sequence input select codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_WARN = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [4:0] spare;
    logic       tout_warn;
    logic       mon_warn;
    logic       tout_en;
    logic       scan_en;
    logic       latch_en;
    logic [2:0] tout_next;
    logic [2:0] mon_next;
    logic [2:0] seq_next;
    logic       seq_level;
    logic [3:0] seq_sel;
    logic [7:0] outputs;
  } state_cfg_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage

//--- src/seq_exit_core.sv
`timescale 1ns/1ps
// Functional notes
// - sequence exit on selected input reaching level
// - sequence delay timer, 10 us to 400 ms
// - monitor exit on any masked input deviation
// - monitor exit has no delay
// - each state entry costs about 20 us load
// - timeout exit when sequence stalls too long
// - timeout per state, 100 us to 400 ms
// - outputs take state levels on entry
// - sticky fault bit per input, two registers
// - fault capture enabled per state
// - eight channels, unselected channels skipped
// - single pass or continuous scan
// - averaging runs the loop sixteen times
// - selected channels' results written together at cycle end
// - results are 12-bit unsigned codes
// - one limit per channel, upper or lower
// - warnings readable and fed to exits
// - scan started by host or state
// - about 500 us per selected channel
// - all warnings ORed into one signal
// - three exits, any state reachable
// - host jump forces sequence exit
module seq_exit_core
  import seq_exit_pkg::*;
#(
  parameter logic [15:0] CONV_CYC = 16'(CONV_CYCLES)
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // apb slave
  input  wire apb_req_type       apb_req,
  output apb_rsp_type            apb_rsp,
  // supply comparators and secondary monitors
  input  wire logic [7:0]        fault_comp_in,
  input  wire logic [3:0]        sec_warn_in,
  // converter
  input  wire logic [11:0]       adc_code,
  output logic [2:0]             adc_channel,
  output logic                   adc_busy,
  // state machine view
  output logic [7:0]             programmable_output_driver,
  output logic [2:0]             seq_state,
  output logic                   warning
);

  typedef struct packed {
    logic [TBL_WORDS-1:0][31:0]  tbl;
    logic [2:0]                  state;
    logic                        loading;
    logic [2:0]                  pend;
    logic [8:0]                  load_cnt;
    logic [7:0]                  tick_cnt;
    logic [15:0]                 seq_cnt;
    logic [15:0]                 tout_cnt;
    logic                        jump;
    logic [7:0]                  out_lvl;
    logic [7:0]                  fault;
    logic [7:0]                  scan_sel;
    logic                        scan_sw_en;
    logic                        scan_cont;
    logic                        scan_avg;
    logic                        scan_busy;
    logic [2:0]                  chan;
    logic [3:0]                  pass;
    logic [15:0]                 conv_cnt;
    logic [NUM_CHAN-1:0][15:0]   acc;
    logic [NUM_CHAN-1:0][11:0]   result;
    logic [NUM_CHAN-1:0][12:0]   limit;
    logic [7:0]                  chan_warn;
    logic                        warning;
    apb_rsp_type                 rsp;
  } core_type;

  core_type q;
  core_type d;

  ////////////////////////////////////////////////////////////////////////////
  function automatic state_cfg_type cfg_of(logic [TBL_WORDS-1:0][31:0] t, logic [2:0] s);
    cfg_of = state_cfg_type'(t[{s, 2'b00}]);
  endfunction

  function automatic logic [31:0] timing_of(logic [TBL_WORDS-1:0][31:0] t, logic [2:0] s);
    timing_of = t[{s, 2'b01}];
  endfunction

  // next selected channel after c; bit 3 set when the loop wraps
  function automatic logic [3:0] next_chan(logic [7:0] sel, logic [2:0] c);
    logic [3:0] r;
    logic [2:0] k;
    r = {1'b1, c};
    for (int i = 7; i >= 1; i--) begin
      k = 3'(c + 3'(i));
      if (sel[k]) begin
        r = {(k <= c), k};
      end
    end
    next_chan = r;
  endfunction

  function automatic logic limit_hit(logic [11:0] res, logic [12:0] lim);
    if (lim[LIMIT_UPPER_BIT]) begin
      limit_hit = res > lim[11:0];
    end else begin
      limit_hit = res < lim[11:0];
    end
  endfunction

  // word 3 of every state slot is a hole and stays unmapped
  function automatic logic tbl_hit(logic [11:0] adr);
    tbl_hit = (adr >= TBL_BASE) && (adr < TBL_END) && (adr[3:2] != 2'b11);
  endfunction

  function automatic logic lim_hit(logic [11:0] adr);
    lim_hit = (adr >= LIMIT_BASE) && (adr < RESULT_BASE);
  endfunction

  function automatic logic res_hit(logic [11:0] adr);
    res_hit = (adr >= RESULT_BASE) && (adr < RESULT_BASE + 12'h020);
  endfunction

  // masked departure of the comparators from the levels a state expects
  function automatic logic [7:0] deviation(logic [31:0] w, logic [7:0] lvl);
    deviation = (lvl ^ w[15:8]) & w[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_cfg_type cur;
  state_cfg_type nxt;
  logic [31:0]   cur_tim;
  logic [7:0]    deviate;
  logic          all_warn;
  logic          seq_cond;
  logic          mon_exit;
  logic          seq_exit;
  logic          tout_exit;
  logic          tick;
  logic          wr_fire;
  logic          rd_fire;
  logic          mapped;
  logic          scan_start;
  logic [3:0]    nc;
  logic [11:0]   a;
  logic [2:0]    tidx;
  logic [7:0]    fault_set;
  logic [7:0]    fault_clr;
  logic [11:0]   avg_res;
  logic [31:0]   rdat;
  logic [15:0]   sum;

  always_comb begin
    d = q;
    sum        = 16'h0000;
    avg_res    = 12'h000;
    nc         = 4'h0;
    a = apb_req.paddr;
    tidx = a[6:4];
    cur = cfg_of(q.tbl, q.state);
    nxt = cfg_of(q.tbl, q.pend);
    cur_tim = timing_of(q.tbl, q.state);
    tick = (q.tick_cnt == 8'(TICK_CYCLES - 1));
    all_warn = (|q.chan_warn) | (|sec_warn_in);
    deviate = deviation(q.tbl[{q.state, 2'b10}], fault_comp_in);

    // apb: access phase answered one cycle after it opens
    wr_fire = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
    rd_fire = apb_req.psel & apb_req.penable & ~q.rsp.pready;
    mapped = (a[1:0] == 2'b00) && ((a <= WARN_OFS) || lim_hit(a) || res_hit(a)
      || tbl_hit(a));

    ////////////////////////////////////////////////////////////////////////////
    // exit detectors
    d.tick_cnt = tick ? 8'h00 : 8'(q.tick_cnt + 8'h01);
    case (cur.seq_sel)
      SEL_NONE: seq_cond = 1'b0;
      SEL_WARN: seq_cond = all_warn ~^ cur.seq_level;
      default:  seq_cond = (cur.seq_sel <= 4'h8) && (fault_comp_in[3'(cur.seq_sel - 4'h1)] == cur.seq_level);
    endcase
    mon_exit  = (|deviate) | (cur.mon_warn & all_warn);
    seq_exit  = q.jump | (seq_cond && q.seq_cnt >= cur_tim[15:0]);
    tout_exit = cur.tout_en & ((q.tout_cnt >= cur_tim[31:16]) | (cur.tout_warn & all_warn));

    // delay timer only runs while the condition holds
    if (!seq_cond) begin
      d.seq_cnt = 16'h0000;
    end else if (tick && q.seq_cnt != 16'hFFFF) begin
      d.seq_cnt = q.seq_cnt + 16'h0001;
    end
    if (tick && q.tout_cnt != 16'hFFFF) begin
      d.tout_cnt = q.tout_cnt + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state machine
    // exits are ignored while a state loads; a pending jump waits
    scan_start = 1'b0;
    if (q.loading) begin
      d.load_cnt = 9'(q.load_cnt + 9'h001);
      if (q.load_cnt == 9'(LOAD_CYCLES - 1)) begin
        d.loading  = 1'b0;
        d.state    = q.pend;
        d.out_lvl  = nxt.outputs;
        d.seq_cnt  = 16'h0000;
        d.tout_cnt = 16'h0000;
        scan_start = nxt.scan_en;
      end
    end else if (mon_exit) begin
      d.loading = 1'b1;
      d.pend    = cur.mon_next;
    end else if (seq_exit) begin
      d.loading = 1'b1;
      d.pend    = cur.seq_next;
      d.jump    = 1'b0;
    end else if (tout_exit) begin
      d.loading = 1'b1;
      d.pend    = cur.tout_next;
    end
    if (d.loading && !q.loading) begin
      d.load_cnt = 9'h000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault latch, capture wins over clear
    fault_set = (cur.latch_en && !q.loading) ? deviate : 8'h00;
    fault_clr = 8'h00;
    if (wr_fire && a == FAULT0_OFS) begin
      fault_clr[FAULT_HALF-1:0] = apb_req.pwdata[FAULT_HALF-1:0];
    end
    if (wr_fire && a == FAULT1_OFS) begin
      fault_clr[7:FAULT_HALF] = apb_req.pwdata[FAULT_HALF-1:0];
    end
    d.fault = (q.fault & ~fault_clr) | fault_set;

    ////////////////////////////////////////////////////////////////////////////
    // round-robin scan
    if (q.scan_busy) begin
      d.conv_cnt = q.conv_cnt + 16'h0001;
      if (q.conv_cnt == CONV_CYC - 16'h0001) begin
        d.conv_cnt = 16'h0000;
        sum = (q.pass == 4'h0) ? {4'h0, adc_code} : 16'(q.acc[q.chan] + {4'h0, adc_code});
        d.acc[q.chan] = sum;
        nc = next_chan(q.scan_sel, q.chan);
        d.chan = nc[2:0];
        if (nc[3]) begin
          if (q.scan_avg && q.pass != 4'(AVG_PASSES - 1)) begin
            d.pass = q.pass + 4'h1;
          end else begin
            d.pass = 4'h0;
            for (int i = 0; i < NUM_CHAN; i++) begin
              avg_res = q.scan_avg ? 12'(d.acc[i] >> AVG_SHIFT) : d.acc[i][11:0];
              if (q.scan_sel[i]) begin
                d.result[i] = avg_res;
                d.chan_warn[i] = limit_hit(avg_res, q.limit[i]);
              end
            end
            if (!q.scan_cont || !(q.scan_sw_en || cur.scan_en)) begin
              d.scan_busy  = 1'b0;
              d.scan_sw_en = 1'b0;
            end
          end
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    // unaligned or unmapped words change nothing
    if (wr_fire && mapped) begin
      if (a == CTRL_OFS && apb_req.pwdata[CTRL_JUMP_BIT]) begin
        d.jump = 1'b1;
      end
      if (a == SCAN_OFS) begin
        d.scan_sel  = apb_req.pwdata[7:0];
        d.scan_cont = apb_req.pwdata[SCAN_CONT_BIT];
        d.scan_avg  = apb_req.pwdata[SCAN_AVG_BIT];
        if (apb_req.pwdata[SCAN_EN_BIT]) begin
          d.scan_sw_en = 1'b1;
          scan_start = 1'b1;
        end
      end
      if (lim_hit(a)) begin
        d.limit[a[4:2]] = apb_req.pwdata[12:0];
      end
      if (tbl_hit(a)) begin
        d.tbl[{tidx, a[3:2]}] = apb_req.pwdata;
      end
    end
    // a scan already running is not restarted; empty selection never starts
    if (scan_start && !q.scan_busy && d.scan_sel != 8'h00) begin
      nc = next_chan(d.scan_sel, 3'h7);
      d.scan_busy = 1'b1;
      d.chan      = nc[2:0];
      d.pass      = 4'h0;
      d.conv_cnt  = 16'h0000;
    end
    d.warning = (|d.chan_warn) | (|sec_warn_in);

    ////////////////////////////////////////////////////////////////////////////
    // register reads
    rdat = 32'h0000_0000;
    if (a == CTRL_OFS || a == STATUS_OFS) begin
      rdat = {26'h0, q.warning, q.scan_busy, q.loading, q.state};
    end else if (a == FAULT0_OFS) begin
      rdat = {28'h0, q.fault[FAULT_HALF-1:0]};
    end else if (a == FAULT1_OFS) begin
      rdat = {28'h0, q.fault[7:FAULT_HALF]};
    end else if (a == SCAN_OFS) begin
      rdat = {21'h0, q.scan_avg, q.scan_cont, q.scan_sw_en, q.scan_sel};
    end else if (a == WARN_OFS) begin
      rdat = {20'h0, sec_warn_in, q.chan_warn};
    end else if (lim_hit(a)) begin
      rdat = {19'h0, q.limit[a[4:2]]};
    end else if (res_hit(a)) begin
      rdat = {20'h0, q.result[a[4:2]]};
    end else if (tbl_hit(a)) begin
      rdat = q.tbl[{tidx, a[3:2]}];
    end
    d.rsp.pready  = rd_fire;
    d.rsp.pslverr = rd_fire & ~mapped;
    d.rsp.prdata  = (rd_fire && mapped && !apb_req.pwrite) ? rdat : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign apb_rsp                    = q.rsp;
  assign adc_channel                = q.chan;
  assign adc_busy                   = q.scan_busy;
  assign programmable_output_driver = q.out_lvl;
  assign seq_state                  = q.state;
  assign warning                    = q.warning;

endmodule

//--- testbench/seq_exit_core_properties.sv
`timescale 1ns/1ps
module seq_exit_checker
  import seq_exit_pkg::*;
#(
  parameter logic [15:0] CONV_CYC = 16'(CONV_CYCLES)
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // bus
  input wire apb_req_type apb_req,
  input wire apb_rsp_type apb_rsp,
  // inputs and outputs
  input wire logic [7:0]  fault_comp_in,
  input wire logic [3:0]  sec_warn_in,
  input wire logic [11:0] adc_code,
  input wire logic [2:0]  adc_channel,
  input wire logic        adc_busy,
  input wire logic [7:0]  programmable_output_driver,
  input wire logic [2:0]  seq_state,
  input wire logic        warning
);
  logic [9:0] gap_q;
  logic [9:0] gap_d;
  logic [2:0] last_q;

  // saturates so a long quiet spell never wraps into a false short gap
  always_comb gap_d = (seq_state != last_q) ? 10'h000 : ((gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gap_q  <= 10'h3FF;
      last_q <= 3'h0;
    end else begin
      gap_q  <= gap_d;
      last_q <= seq_state;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held longer than one cycle");
  chk_ready_time: assert property (apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready)
    else $error("pready not two cycles after setup");
  chk_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
    else $error("prdata not zero outside answer");
  chk_out_state: assert property ($stable(seq_state) |-> $stable(programmable_output_driver))
    else $error("outputs moved without a state change");
  chk_load_gap: assert property ((seq_state != last_q) |-> gap_q >= 10'd399)
    else $error("state changed before load time");
  // valid only for conversion slots of seven cycles or more
  chk_chan_hold: assert property ($rose(adc_busy) |=> $stable(adc_channel)[*6])
    else $error("channel left its slot early");
  chk_warn_sec: assert property ((|sec_warn_in) |-> ##[1:2] warning)
    else $error("secondary warning not seen on warning");

  cover property ($changed(seq_state));
  cover property ($rose(adc_busy));
  cover property (apb_rsp.pslverr);
  cover property ($rose(warning));
endmodule

bind seq_exit_core seq_exit_checker #(.CONV_CYC(CONV_CYC)) i_seq_exit_checker (
  .sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .fault_comp_in(fault_comp_in), .sec_warn_in(sec_warn_in), .adc_code(adc_code),
  .adc_channel(adc_channel), .adc_busy(adc_busy), .programmable_output_driver(programmable_output_driver),
  .seq_state(seq_state), .warning(warning)
);

//--- testbench/adc_model.sv
`timescale 1ns/1ps
module adc_model (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_b,
  // converter control
  input wire logic [2:0]       adc_channel,
  input wire logic             adc_busy,
  input wire logic [7:0][11:0] chan_lvl,
  // result
  output logic [11:0]          adc_code
);
  // idle output keeps flipping so a stray sample never passes for a result
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      adc_code <= 12'h000;
    end else begin
      adc_code <= adc_busy ? chan_lvl[adc_channel] : ~adc_code;
    end
  end
endmodule

//--- testbench/tb_seq_exit_core.sv
`timescale 1ns/1ps
module tb_seq_exit_core
  import seq_exit_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } row_type;
  logic             sys_clk       = 1'b0;
  logic             rst_b         = 1'b0;
  apb_req_type      apb_req       = '0;
  apb_rsp_type      apb_rsp;
  logic [7:0]       fault_comp_in = 8'h02;
  logic [3:0]       sec_warn_in   = 4'h0;
  logic [7:0][11:0] chan_lvl      = '0;
  logic [11:0]      adc_code;
  logic [2:0]       adc_channel;
  logic             adc_busy;
  logic [7:0]       pod;
  logic [2:0]       seq_state;
  logic             warning;
  logic [31:0]      rd;
  logic             er;
  int               bad_count = 0;
  int               n_checks  = 0;
  int               cyc       = 0;
  int               busy_n    = 0;
  row_type          rows [5];

  seq_exit_core #(.CONV_CYC(16'h0008)) i_seq_exit_core (
    .sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fault_comp_in(fault_comp_in), .sec_warn_in(sec_warn_in), .adc_code(adc_code),
    .adc_channel(adc_channel), .adc_busy(adc_busy), .programmable_output_driver(pod),
    .seq_state(seq_state), .warning(warning));
  adc_model i_adc_model (.sys_clk(sys_clk), .rst_b(rst_b), .adc_channel(adc_channel),
    .adc_busy(adc_busy), .chan_lvl(chan_lvl), .adc_code(adc_code));

  ////////////////////////////////////////////////////////////////////////////
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (adc_busy === 1'b1) busy_n++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // counts edges until the state shows, then judges the latency window
  task automatic wait_state(input logic [2:0] s, input int lo, input int hi);
    int n;
    n = 0;
    while (seq_state !== s && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
    chk({29'h0, seq_state}, {29'h0, s});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (adc_busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, adc_busy}, 32'h0);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{LIMIT_BASE + 12'h004, 32'h0000_1ABC, 32'h0000_1ABC, 1'b0};
    rows[1] = '{12'h018, 32'h1234_5678, 32'h0, 1'b1};
    rows[2] = '{12'h002, 32'h0000_00FF, 32'h0, 1'b1};
    rows[3] = '{RESULT_BASE, 32'h0000_0FFF, 32'h0, 1'b0};
    rows[4] = '{TBL_BASE + 12'h078, 32'h0000_0303, 32'h0000_0303, 1'b0};
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(STATUS_OFS, 32'h0);
    chk({24'h0, pod}, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].r);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    $display("test register rows done");
    sec_warn_in <= 4'h8;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, warning}, 32'h1);
    rdc(WARN_OFS, 32'h0000_0800);
    sec_warn_in <= 4'h0;
    $display("test secondary warning done");
    chan_lvl[0] <= 12'hFFF;
    chan_lvl[1] <= 12'h555;
    chan_lvl[2] <= 12'h800;
    wr(LIMIT_BASE, 32'h0000_0100);
    wr(LIMIT_BASE + 12'h008, 32'h0000_17FF);
    busy_n = 0;
    wr(SCAN_OFS, 32'h0000_0105);
    @(posedge sys_clk);
    chk({29'h0, adc_channel}, 32'h0);
    repeat (8) @(posedge sys_clk);
    chk({29'h0, adc_channel}, 32'h2);
    wait_idle();
    chk({31'h0, (busy_n >= 16 && busy_n <= 18)}, 32'h1);
    rdc(RESULT_BASE, 32'h0000_0FFF);
    rdc(RESULT_BASE + 12'h004, 32'h0);
    rdc(RESULT_BASE + 12'h008, 32'h0000_0800);
    rdc(WARN_OFS, 32'h0000_0004);
    rdc(SCAN_OFS, 32'h0000_0005);
    chk({31'h0, warning}, 32'h1);
    wr(SCAN_OFS, 32'h0000_0305);
    repeat (60) @(posedge sys_clk);
    chk({31'h0, adc_busy}, 32'h1);
    wr(SCAN_OFS, 32'h0000_0005);
    wait_idle();
    chan_lvl[0] <= 12'h123;
    busy_n = 0;
    wr(SCAN_OFS, 32'h0000_0505);
    repeat (100) @(posedge sys_clk);
    rdc(RESULT_BASE, 32'h0000_0FFF);
    wait_idle();
    chk({31'h0, (busy_n >= 256 && busy_n <= 258)}, 32'h1);
    rdc(RESULT_BASE, 32'h0000_0123);
    $display("test scan done");
    wr(TBL_BASE + 12'h004, 32'h0000_0001);
    wr(TBL_BASE + 12'h010, 32'h0042_005A);
    wr(TBL_BASE + 12'h018, 32'h0000_0202);
    wr(TBL_BASE + 12'h020, 32'h0118_003C);
    wr(TBL_BASE + 12'h024, 32'h000A_0000);
    wr(TBL_BASE + 12'h030, 32'h0000_80C3);
    wr(TBL_BASE, 32'h0000_3100);
    fault_comp_in <= 8'h03;
    wait_state(3'h1, 401, 820);
    chk({24'h0, pod}, 32'h0000_005A);
    fault_comp_in <= 8'h01;
    wait_state(3'h2, 401, 406);
    rdc(FAULT0_OFS, 32'h0000_0002);
    wr(FAULT0_OFS, 32'h0000_0002);
    rdc(FAULT0_OFS, 32'h0);
    wait_state(3'h3, 2150, 2450);
    chk({24'h0, pod}, 32'h0000_00C3);
    wr(TBL_BASE + 12'h040, 32'h0080_0000);
    wr(TBL_BASE + 12'h048, 32'h0000_0404);
    wr(CTRL_OFS, 32'h0000_0001);
    wait_state(3'h4, 399, 410);
    chk({31'h0, adc_busy}, 32'h1);
    rdc(FAULT0_OFS, 32'h0);
    $display("test sequencer done");
    rst_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk({28'h0, adc_busy, seq_state}, 32'h0);
    chk({24'h0, pod}, 32'h0);
    rdc(TBL_BASE, 32'h0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
